/* rtl/dsir_irq_ctrl.sv */
// interrupt control unit with dac rate source
// Function
// R1: eight sources each gated by mask bit
// R2: mask write effective within six cycles
// R3: block strobe write increments nesting count
// R4: unblock strobe decrements, saturates at zero
// R5: deliver only while nesting count zero
// R6: accepting an interrupt increments count
// R7: service software writes unblock last
// R8: nesting count readable and writable, 5 bits
// R9: strobes take effect within six cycles
// R10: add 20-bit increment every fourth clock
// R11: overflow latches samples, raises dac request
// R12: registers reset zero, processor read/write
// R13: fixed priority, highest bit first, clear
`include "dsir_map.svh"
module dsir_irq_ctrl
   import dsir_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire dsir_bus_t   bus,
   output logic [15:0]      rdata,
   input  wire logic [7:1]  src_event,
   output logic             irq_req,
   output logic [2:0]       irq_vector,
   input  wire logic        irq_ack,
   output dsir_pcm_t        pcm_out,
   output logic             pcm_strobe
);
   typedef struct packed {
      logic [15:0] rate_low;
      logic [15:0] rate_high;
      dsir_pcm_t   pcm;
      logic [7:0]  mask;
      logic [4:0]  count;
      logic [7:0]  pending;
      dsir_state_t state;
      logic [2:0]  vector;
      logic        req;
      dsir_pcm_t   pcm_q;
      logic        pcm_stb;
      logic [15:0] rdata;
   } dsir_ctl_t;

   dsir_ctl_t   ctl_reg;
   dsir_ctl_t   ctl_next;
   logic [1:0]  rst_sync;
   logic        rst_int_b;
   logic        dac_tick;
   logic [7:0]  live;
   logic [2:0]  pick;
   logic        any_live;
   logic [19:0] increment;
   logic        wr_block;
   logic        wr_unblock;

   // ==================================================
   // reset release through two flops
   // assertion stays asynchronous, release lands on a clean edge
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_int_b = rst_sync[1];

   // upper twelve bits of the high word never feed the rate
   // R10: increment from high nibble and low word
   assign increment = {ctl_reg.rate_high[`DSIR_RATE_HIGH_BITS-1:0],
                       ctl_reg.rate_low};

   // phase accumulator raises the dac tick on carry out
   dsir_rate_acc dsir_rate_acc_inst
   (
      .clock     (clock),
      .rst_b     (rst_int_b),
      .increment (increment),
      .overflow  (dac_tick)
   );

   // ==================================================
   // strobe decode, the written data word is ignored
   // R3: block strobe address
   assign wr_block   = bus.wr && (bus.addr == `DSIR_OFS_BLOCK);
   // R4: unblock strobe address
   assign wr_unblock = bus.wr && (bus.addr == `DSIR_OFS_UNBLOCK);

   // ==================================================
   // live requests, withdrawn at once by a mask or block write
   // R1: gate pending requests by the mask
   // R5: nothing offered while nesting count nonzero
   assign live     = ctl_reg.pending & ctl_reg.mask;
   assign any_live = (live != 8'h00) && (ctl_reg.count == 5'h00);

   // upward scan keeps the last hit, the highest bit
   // R13: highest set bit wins
   always_comb
   begin
      pick = 3'h0;
      for (int i = 0; i < `DSIR_SRC_COUNT; i++)
      begin
         if (live[i])
            pick = 3'(i);
      end
   end

   // ==================================================
   // register writes, request capture and delivery
   always_comb
   begin
      ctl_next         = ctl_reg;
      ctl_next.pcm_stb = 1'b0;
      ctl_next.rdata   = 16'h0000;

      // R12: processor write path
      if (bus.wr)
      begin
         case (bus.addr)
            `DSIR_OFS_RATE_LOW:  ctl_next.rate_low  = bus.wdata;
            `DSIR_OFS_RATE_HIGH: ctl_next.rate_high = bus.wdata;
            `DSIR_OFS_LEFT:      ctl_next.pcm.left  = bus.wdata;
            `DSIR_OFS_RIGHT:     ctl_next.pcm.right = bus.wdata;
            // high byte of a mask write is dropped
            // R2: mask applies next cycle
            `DSIR_OFS_MASK:      ctl_next.mask      = bus.wdata[7:0];
            // R8: direct count write
            `DSIR_OFS_COUNT:     ctl_next.count     = bus.wdata[4:0];
            default:             ;
         endcase
      end

      // a nest of 32 wraps to zero, software keeps below that
      // R3: block strobe, data ignored; R9: next cycle
      if (wr_block)
         ctl_next.count = ctl_reg.count + 5'h01;
      // zero test keeps a stray unblock from wrapping to 31
      // R4: unblock strobe saturates at zero
      else if (wr_unblock && (ctl_reg.count != 5'h00))
         ctl_next.count = ctl_reg.count - 5'h01;

      // strobe and foreign addresses read as zero
      // R12: processor read path, one cycle later
      if (bus.rd)
      begin
         case (bus.addr)
            `DSIR_OFS_RATE_LOW:  ctl_next.rdata = ctl_reg.rate_low;
            `DSIR_OFS_RATE_HIGH: ctl_next.rdata = ctl_reg.rate_high;
            `DSIR_OFS_LEFT:      ctl_next.rdata = ctl_reg.pcm.left;
            `DSIR_OFS_RIGHT:     ctl_next.rdata = ctl_reg.pcm.right;
            `DSIR_OFS_MASK:      ctl_next.rdata = {8'h00, ctl_reg.mask};
            `DSIR_OFS_COUNT:     ctl_next.rdata = {11'h000, ctl_reg.count};
            default:             ctl_next.rdata = 16'h0000;
         endcase
      end

      // a copy keeps the pair whole while software rewrites it
      // R11: overflow latches samples and raises dac request
      if (dac_tick)
      begin
         ctl_next.pcm_q   = ctl_reg.pcm;
         ctl_next.pcm_stb = 1'b1;
      end

      // delivery handshake with the core
      // wait gives the raised count one cycle to settle
      case (ctl_reg.state)
         DSIR_IDLE:
         begin
            if (any_live)
            begin
               ctl_next.vector = pick;
               ctl_next.state  = DSIR_OFFER;
            end
         end
         DSIR_OFFER:
         begin
            if (irq_ack)
            begin
               // R13: clear the accepted request
               ctl_next.pending[ctl_reg.vector] = 1'b0;
               // R6: acceptance blocks further delivery
               ctl_next.count = ctl_next.count + 5'h01;
               ctl_next.state = DSIR_WAIT;
            end
            else if (!any_live)
               // withdrawn by mask or block before acceptance
               ctl_next.state = DSIR_IDLE;
            else
               ctl_next.vector = pick;
         end
         DSIR_WAIT:
            ctl_next.state = DSIR_IDLE;
         default:
            ctl_next.state = DSIR_IDLE;
      endcase

      // new events win over the acceptance clear
      ctl_next.pending = ctl_next.pending | {src_event, dac_tick};

      // request flag kept in its own flop so the pin is clean
      ctl_next.req = (ctl_next.state == DSIR_OFFER);
   end

   always_ff @(posedge clock or negedge rst_int_b)
   begin
      if (!rst_int_b)
         ctl_reg <= '0;
      else
         ctl_reg <= ctl_next;
   end

   // ==================================================
   // outputs straight from flops
   // the request pin has a flop of its own, no state decode
   assign rdata      = ctl_reg.rdata;
   assign irq_req    = ctl_reg.req;
   assign irq_vector = ctl_reg.vector;
   assign pcm_out    = ctl_reg.pcm_q;
   assign pcm_strobe = ctl_reg.pcm_stb;
endmodule // dsir_irq_ctrl

/* rtl/dsir_map.svh */
// register offsets, field positions and reset values of the interrupt block
`ifndef DSIR_MAP_SVH
`define DSIR_MAP_SVH
// ==================================================
// register offsets in the i/o space
`define DSIR_OFS_RATE_LOW    16'hC013
`define DSIR_OFS_RATE_HIGH   16'hC014
`define DSIR_OFS_LEFT        16'hC015
`define DSIR_OFS_RIGHT       16'hC016
`define DSIR_OFS_MASK        16'hC01A
`define DSIR_OFS_BLOCK       16'hC01B
`define DSIR_OFS_UNBLOCK     16'hC01C
`define DSIR_OFS_COUNT       16'hC01D
// ==================================================
// source bit positions in the mask
`define DSIR_BIT_TIMER_ONE   3'h7
`define DSIR_BIT_TIMER_ZERO  3'h6
`define DSIR_BIT_SER_RX      3'h5
`define DSIR_BIT_SER_TX      3'h4
`define DSIR_BIT_MODULATOR   3'h3
`define DSIR_BIT_DATA_IN     3'h2
`define DSIR_BIT_CTRL_PORT   3'h1
`define DSIR_BIT_DAC         3'h0
// ==================================================
// reset values and timing
`define DSIR_RST_ZERO16      16'h0000
`define DSIR_RST_MASK        8'h00
`define DSIR_RST_COUNT       5'h00
`define DSIR_RATE_DIV        2'h3
`define DSIR_RATE_HIGH_BITS  4
`define DSIR_SRC_COUNT       8
`define DSIR_BLOCK_DELAY_CYC 6
`endif

/* rtl/dsir_pkg.sv */
// types shared by the interrupt block and its rate accumulator
package dsir_pkg;
   // ==================================================
   // processor i/o access
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsir_bus_t;

   // ==================================================
   // sample pair handed to the converter
   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } dsir_pcm_t;

   // delivery handshake states, gray along idle-offer-wait
   typedef enum logic [1:0] {
      DSIR_IDLE  = 2'b00,
      DSIR_OFFER = 2'b01,
      DSIR_WAIT  = 2'b11
   } dsir_state_t;
endpackage

/* rtl/dsir_rate_acc.sv */
// dac sample-rate phase accumulator
`include "dsir_map.svh"
module dsir_rate_acc
   import dsir_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [19:0] increment,
   output logic             overflow
);
   typedef struct packed {
      logic [1:0]  div;
      logic [25:0] phase;
      logic        ovf;
   } dsir_acc_t;

   dsir_acc_t acc_reg;
   dsir_acc_t acc_next;
   logic [26:0] sum;

   // ==================================================
   // add once every fourth clock, carry out is the sample tick
   // R10: four-cycle accumulate
   always_comb
   begin
      acc_next     = acc_reg;
      acc_next.div = acc_reg.div + 2'h1;
      acc_next.ovf = 1'b0;
      sum          = {1'b0, acc_reg.phase} + {7'h00, increment};
      if (acc_reg.div == `DSIR_RATE_DIV)
      begin
         acc_next.phase = sum[25:0];
         acc_next.ovf   = sum[26];
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         acc_reg <= '0;
      else
         acc_reg <= acc_next;
   end

   assign overflow = acc_reg.ovf;
endmodule // dsir_rate_acc

/* verif/dsir_irq_ctrl_chk.sv */
// port checker for the interrupt block
// ======================================
module dsir_irq_ctrl_chk
   import dsir_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_b,
   input wire dsir_bus_t   bus,
   input wire logic [15:0] rdata,
   input wire logic [7:1]  src_event,
   input wire logic        irq_req,
   input wire logic [2:0]  irq_vector,
   input wire logic        irq_ack,
   input wire dsir_pcm_t   pcm_out,
   input wire logic        pcm_strobe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic [7:0] msk_reg;
   logic [4:0] cnt_reg;
   logic       acc;
   logic [4:0] base;
   // shadow of mask and count, accept adds on top
   assign acc = irq_req && irq_ack;
   assign base = !bus.wr ? cnt_reg
      : bus.addr == 16'hC01D ? bus.wdata[4:0]
      : bus.addr == 16'hC01B ? cnt_reg + 5'h01
      : bus.addr == 16'hC01C && cnt_reg != 5'h00 ? cnt_reg - 5'h01
      : cnt_reg;
   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
      begin
         msk_reg <= 8'h00;
         cnt_reg <= 5'h00;
      end
      else
      begin
         cnt_reg <= base + {4'h0, acc};
         if (bus.wr && bus.addr == 16'hC01A)
            msk_reg <= bus.wdata[7:0];
      end
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
      else $error("rdata not zero");
   a_count_read: assert property (bus.rd && bus.addr == 16'hC01D
      |=> rdata == {11'h000, $past(cnt_reg)}) else $error("count read");
   a_block_quiet: assert property (cnt_reg != 5'h00 [*6] |-> !irq_req)
      else $error("offer while blocked");
   a_vec_masked: assert property ($stable(msk_reg) [*6] ##0 irq_req
      |-> msk_reg[irq_vector]) else $error("masked source offered");
   a_ack_drop: assert property (acc |=> !irq_req)
      else $error("offer after accept");
   a_evt_offer: assert property (src_event[7] && msk_reg[7]
      && cnt_reg == 5'h00 |-> ##[1:6] irq_req) else $error("no offer");
   a_pcm_space: assert property (pcm_strobe |=> !pcm_strobe [*3])
      else $error("strobe spacing");
   a_pcm_hold: assert property (!pcm_strobe |-> $stable(pcm_out))
      else $error("samples moved");
   c_accept: cover property (acc);
   c_pcm: cover property (pcm_strobe);
   c_block: cover property (bus.wr && bus.addr == 16'hC01B);
endmodule // dsir_irq_ctrl_chk
bind dsir_irq_ctrl dsir_irq_ctrl_chk dsir_irq_ctrl_chk_inst (.clock(clock),
   .rst_b(rst_b), .bus(bus), .rdata(rdata), .src_event(src_event),
   .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
   .pcm_out(pcm_out), .pcm_strobe(pcm_strobe));

/* verif/dsir_irq_ctrl_tb_top.sv */
// self-checking bench for the interrupt block
// ======================================
module dsir_irq_ctrl_tb_top
   import dsir_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
   logic        clock, rst_b, irq_ack, irq_req, pcm_strobe, rd_d;
   dsir_bus_t   bus;
   logic [15:0] rdata, a, d, exp_v, q[$];
   logic [7:1]  src_event;
   logic [2:0]  irq_vector;
   dsir_pcm_t   pcm_out;
   int          err_count, checked, seed, i;
   dsir_irq_ctrl dsir_irq_ctrl_inst (.clock(clock), .rst_b(rst_b),
      .bus(bus), .rdata(rdata), .src_event(src_event), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .pcm_out(pcm_out),
      .pcm_strobe(pcm_strobe));
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // ======================================
   // drivers, all launched at the falling edge
   task automatic wr(input logic [15:0] ad, input logic [15:0] dd);
      @(negedge clock);
      bus = '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: dd};
      @(negedge clock);
      bus.wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] ad, input logic [15:0] x);
      @(negedge clock);
      bus.rd = 1'b1;
      bus.addr = ad;
      q.push_back(x);
      @(negedge clock);
      bus.rd = 1'b0;
   endtask
   task automatic pulse(input logic [7:1] s);
      @(negedge clock);
      src_event = s;
      @(negedge clock);
      src_event = 7'h00;
   endtask
   task automatic quiet();
      repeat (8) @(negedge clock);
      `CHK("req", 1'b0, irq_req)
   endtask
   // bounded wait for an offer, then accept it
   task automatic take(input logic [2:0] v);
      for (i = 0; i < 40 && irq_req !== 1'b1; i++) @(negedge clock);
      `CHK("req", 1'b1, irq_req)
      irq_ack = 1'b1;
      q.push_back({13'h0000, v});
      @(negedge clock);
      irq_ack = 1'b0;
   endtask
   task automatic conclude();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // read data comes back one edge late, an accepted vector on the accept edge itself; oldest note first
   always @(posedge clock)
   begin
      if (rd_d === 1'b1 || (irq_req && irq_ack) === 1'b1)
      begin
         // pop once, the macro reads its expectation twice
         exp_v = q.pop_front();
         `CHK("result", exp_v, rd_d ? rdata : {13'h0, irq_vector})
      end
      rd_d = bus.rd;
   end
   initial
   begin
      #40000;
      err_count++;
      conclude();
   end
   initial
   begin
      seed = 86056;
      {bus, src_event, irq_ack, rst_b, rd_d} = '0;
      repeat (16) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      for (a = 16'hC010; a < 16'hC01F; a++) rd(a, 16'h0000);
      // random fill; strobes and foreign places read zero
      for (a = 16'hC011; a < 16'hC01E; a++)
      begin
         d = 16'($random(seed));
         wr(a, d);
         rd(a, a == 16'hC01A ? d & 16'h00FF : a == 16'hC01D ? d & 16'h001F
            : a > 16'hC016 || a < 16'hC013 ? 16'h0000 : d);
      end
      wr(16'hC01A, 16'h00C0);
      wr(16'hC01D, 16'h0000);
      wr(16'hC01C, d);
      rd(16'hC01D, 16'h0000);
      wr(16'hC01B, d);
      wr(16'hC01B, 16'h0000);
      rd(16'hC01D, 16'h0002);
      wr(16'hC01C, d);
      wr(16'hC01C, d);
      pulse(7'h70);
      take(3'h7);
      rd(16'hC01D, 16'h0001);
      wr(16'hC01C, d);
      take(3'h6);
      wr(16'hC01C, d);
      quiet();
      wr(16'hC01B, d);
      pulse(7'h40);
      quiet();
      wr(16'hC01C, d);
      take(3'h7);
      wr(16'hC01C, d);
      wr(16'hC01A, 16'h0020);
      take(3'h5);
      wr(16'hC01C, d);
      // rate of all ones: upper bits of the high word must not count
      wr(16'hC015, a);
      wr(16'hC016, d);
      wr(16'hC013, 16'hFFFF);
      wr(16'hC014, 16'hFFFF);
      wr(16'hC01A, 16'h0001);
      for (i = 0; i < 600 && pcm_strobe !== 1'b1; i++) @(posedge clock);
      @(posedge clock);
      for (i = 1; i < 600 && pcm_strobe !== 1'b1; i++) @(posedge clock);
      @(negedge clock); // drive and compare off the sampling edge
      `CHK("gap", 1'b1, i == 256 || i == 260)
      `CHK("pcm", {a, d}, pcm_out)
      take(3'h0);
      wr(16'hC01C, d);
      conclude();
   end
endmodule // dsir_irq_ctrl_tb_top
